// file: core/twi_wait_defines.vh
// Constants for the two-wire wait and interrupt controller.
// Included by the controller only, not by its line sampler; definitions only.
`ifndef TWI_WAIT_DEFINES_VH
`define TWI_WAIT_DEFINES_VH
`define RELEASE_ALL_BYTE   8'hff
`define EXT_HI_ZERO        4'h0
`define EXT_HI_ONE         4'hf
`define TEN_BIT_PREFIX     5'h1e
`define GEN_CALL_ADDR      7'h00
`define CLK_ADDR_LAST      4'h9
`define CLK_EIGHT          4'h8
`define CLK_NINE           4'h9
`define CTL_STOP_BIT       0
`define CTL_START_BIT      1
`define CTL_ACKE_BIT       2
`define CTL_WTIM_BIT       3
`define CTL_SPIE_BIT       4
`define CTL_WREL_BIT       5
`define CTL_LREL_BIT       6
`define STS_COI_BIT        4
`define STS_EXC_BIT        5
`define CNT_RESET          4'h0
`define CNT_START          4'hf
`endif

// file: core/twi_line_sync.v
// Two-flop synchroniser with edge detection for one bus line.
// Assumes the line is asynchronous to clk_in; outputs are on clk_in.
`timescale 1ns/1ps
module twi_line_sync (
   input  wire clk_in,
   input  wire nrst_in,
   input  wire ce_in,
   input  wire line_in,
   output wire level_out,
   output wire rise_out,
   output wire fall_out
);
   reg meta_r;
   reg sync_r;
   reg last_r;
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         last_r <= 1'b1;
      end else if (ce_in) begin
         meta_r <= line_in;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end
   assign level_out = sync_r;
   assign rise_out  = sync_r & ~last_r;
   assign fall_out  = ~sync_r & last_r;
endmodule // twi_line_sync

// file: core/twi_wait_ctrl.v
// Two-wire controller core: waits, interrupt timing, address match,
// extension codes, transmit check and arbitration loss.
// Assumes clk_in far faster than the serial clock; control bits are
// one-cycle strobes or levels from software on clk_in.
//
// Behaviour
// RULE_01 - Waiting device holds clock line low
// RULE_02 - Receive wait ends on release or FFH
// RULE_03 - Transmit wait ends on data write
// RULE_04 - Master wait also ends on start/stop
// RULE_05 - Data wait at clock 8 or 9
// RULE_06 - Slave match: interrupt, wait at clock 9
// RULE_07 - Address match always drives acknowledge
// RULE_08 - Extension code interrupts at clock 8
// RULE_09 - Restart mismatch: interrupt, no wait
// RULE_10 - Foreign address: no interrupt, no wait
// RULE_11 - Master address wait always clock 9
// RULE_12 - Events align to serial clock falls
// RULE_13 - Software sets acknowledge before releasing wait
// RULE_14 - Stop interrupt only when enabled
// RULE_15 - Compare address, interrupt on match/extension
// RULE_16 - Capture line levels while transmitting
// RULE_17 - Upper nibble 0000/1111 flags extension
// RULE_18 - Ten-bit prefix sets extension and coincidence
// RULE_19 - Bus release leaves slave operation
// RULE_20 - Classify general call, start byte, ten-bit
// RULE_21 - Masters clock together until data differs
// RULE_22 - Arbitration loss flags and releases lines
// RULE_23 - Post-loss interrupt at clock 8/9 (code: clock 9 only, when wait_timing_select_in is set)
// RULE_24 - Stop during loss interrupts at stop
// RULE_25 - Post-loss clock nine or extension eight (code: clock nine only when wait_timing_select_in is set)
// RULE_26 - Software enables stop interrupt for arbitration
// RULE_27 - Interrupt is one-cycle pulse
`timescale 1ns/1ps
`include "twi_wait_defines.vh"
module twi_wait_ctrl (
   input  wire       clk_in,
   input  wire       nrst_in,
   input  wire       ce_in,
   input  wire       scl_in,
   output wire       scl_out,
   output wire       scl_oe_out,
   input  wire       sda_in,
   output wire       sda_out,
   output wire       sda_oe_out,
   input  wire       master_mode_in,
   input  wire       wait_timing_select_in,
   input  wire       auto_ack_enable_in,
   input  wire       stop_interrupt_enable_in,
   input  wire       wait_release_in,
   input  wire       start_request_in,
   input  wire       stop_request_in,
   input  wire       bus_release_request_in,
   input  wire       data_write_in,
   input  wire [7:0] data_in,
   input  wire [6:0] own_slave_address_in,
   input  wire       flags_clear_in,
   output wire [7:0] shift_register_out,
   output wire       serial_irq_out,
   output wire       waiting_out,
   output wire       extension_code_flag_out,
   output wire       address_coincidence_flag_out,
   output wire       arbitration_lost_flag_out,
   output wire       start_detected_flag_out,
   output wire       stop_detected_out,
   output wire       transmit_error_out,
   output wire       general_call_out,
   output wire       start_byte_out,
   output wire       ten_bit_out,
   output wire       slave_selected_out
);
   wire scl_s;
   wire scl_rise;
   wire scl_fall;
   wire sda_s;
   wire sda_rise;
   wire sda_fall;

   twi_line_sync u_scl (
      .clk_in   (clk_in),
      .nrst_in  (nrst_in),
      .ce_in    (ce_in),
      .line_in  (scl_in),
      .level_out(scl_s),
      .rise_out (scl_rise),
      .fall_out (scl_fall)
   );
   twi_line_sync u_sda (
      .clk_in   (clk_in),
      .nrst_in  (nrst_in),
      .ce_in    (ce_in),
      .line_in  (sda_in),
      .level_out(sda_s),
      .rise_out (sda_rise),
      .fall_out (sda_fall)
   );

   // Upper nibble reserved for extension codes
   function is_ext;
      input [6:0] a;
      begin
         is_ext = (a[6:3] == `EXT_HI_ZERO) || (a[6:3] == `EXT_HI_ONE);
      end
   endfunction

   // Byte phase of the current transfer
   localparam ST_IDLE = 2'h0;
   localparam ST_ADDR = 2'h1;
   localparam ST_DATA = 2'h2;
   localparam ST_OFF  = 2'h3;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [3:0] clk_cnt_r;
   reg [7:0] shift_r;
   reg [7:0] sent_r;
   reg       wait_r;
   reg       irq_r;
   reg       exc_r;
   reg       coi_r;
   reg       ald_r;
   reg       std_r;
   reg       spd_r;
   reg       txerr_r;
   reg       gcall_r;
   reg       sbyte_r;
   reg       tenb_r;
   reg       selected_r;
   reg       transmit_r;
   reg       restart_r;
   reg       lost_r;
   reg       sda_drv_r;
   reg       ack_drv_r;
   reg       ext_byte_r;

   // Both lines share one sync depth, so their edges line up
   wire start_cond = sda_fall & scl_s;
   wire stop_cond  = sda_rise & scl_s;
   wire [3:0] clk_no = clk_cnt_r + 4'h1;
   // Address sits above the direction bit
   wire [6:0] rx_addr = shift_r[7:1];
   wire addr_match = (rx_addr == own_slave_address_in);
   wire ext_code   = is_ext(rx_addr);
   wire data_point = wait_timing_select_in ? (clk_no == `CLK_NINE) : (clk_no == `CLK_EIGHT);
   wire is_master  = master_mode_in & ~lost_r;

   // RULE_02 receive release
   wire rel_rx = wait_release_in | (data_write_in & (data_in == `RELEASE_ALL_BYTE));
   // RULE_03 transmit release
   wire rel_tx = data_write_in;
   // RULE_04 master-only release
   wire rel_m  = is_master & (start_request_in | stop_request_in);
   // Bus release also frees a pending wait
   wire release_now = (transmit_r ? rel_tx : rel_rx) | rel_m | bus_release_request_in;

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: if (start_cond) state_nxt = ST_ADDR;
         ST_ADDR: if (scl_fall && clk_no == `CLK_ADDR_LAST) state_nxt = ST_DATA;
         ST_DATA: if (bus_release_request_in) state_nxt = ST_OFF;
         ST_OFF:  state_nxt = ST_OFF;
         default: state_nxt = ST_IDLE;
      endcase
      // Bus conditions override the byte sequence
      if (start_cond)
         state_nxt = ST_ADDR;
      if (stop_cond)
         state_nxt = ST_IDLE;
   end

   always @(posedge clk_in) begin
      if (!nrst_in) begin
         state_r    <= ST_IDLE;
         clk_cnt_r  <= `CNT_RESET;
         shift_r    <= 8'h00;
         sent_r     <= 8'h00;
         wait_r     <= 1'b0;
         irq_r      <= 1'b0;
         exc_r      <= 1'b0;
         coi_r      <= 1'b0;
         ald_r      <= 1'b0;
         std_r      <= 1'b0;
         spd_r      <= 1'b0;
         txerr_r    <= 1'b0;
         gcall_r    <= 1'b0;
         sbyte_r    <= 1'b0;
         tenb_r     <= 1'b0;
         selected_r <= 1'b0;
         transmit_r <= 1'b0;
         restart_r  <= 1'b0;
         lost_r     <= 1'b0;
         sda_drv_r  <= 1'b0;
         ack_drv_r  <= 1'b0;
         ext_byte_r <= 1'b0;
      end else if (ce_in) begin
         state_r <= state_nxt;
         irq_r   <= 1'b0;
         // Clear first so that a set later in this cycle wins
         if (flags_clear_in) begin
            exc_r   <= 1'b0;
            coi_r   <= 1'b0;
            ald_r   <= 1'b0;
            txerr_r <= 1'b0;
         end
         if (data_write_in) begin
            shift_r    <= data_in;
            sent_r     <= data_in;
            // A slave takes its direction from the address bit
            if (is_master)
               transmit_r <= 1'b1;
            sda_drv_r  <= ~data_in[7];
         end
         if (release_now)
            wait_r <= 1'b0;
         // Ninth clock carries the acknowledge; the byte stays intact
         if (scl_rise && !wait_r && clk_no != `CLK_NINE) begin
            // RULE_16 capture actual line
            shift_r <= {shift_r[6:0], sda_s};
            // RULE_21 arbitration compare
            if (is_master && sda_drv_r == 1'b0 && !sda_s) begin
               // RULE_22 loss flag
               ald_r  <= 1'b1;
               lost_r <= 1'b1;
            end
         end
         // RULE_12 falling-edge sync
         if (scl_fall && (state_r == ST_ADDR || state_r == ST_DATA)) begin
            clk_cnt_r <= (clk_no == `CLK_NINE) ? `CNT_RESET : clk_no;
            ack_drv_r <= 1'b0;
            sda_drv_r <= (transmit_r && !lost_r && clk_no < `CLK_EIGHT) ? ~shift_r[7] : 1'b0;
            if (state_r == ST_ADDR) begin
               if (clk_no == `CLK_EIGHT && !is_master) begin
                  // RULE_20 reserved classes
                  gcall_r <= (shift_r[7:1] == `GEN_CALL_ADDR) & ~shift_r[0];
                  sbyte_r <= (shift_r[7:1] == `GEN_CALL_ADDR) & shift_r[0];
                  tenb_r  <= (shift_r[7:3] == `TEN_BIT_PREFIX);
                  // RULE_15 compare address
                  if (addr_match) begin
                     // RULE_07 forced acknowledge
                     ack_drv_r  <= 1'b1;
                     selected_r <= 1'b1;
                     // RULE_18 ten-bit coincidence
                     coi_r <= 1'b1;
                  end
                  ext_byte_r <= ext_code;
                  if (ext_code) begin
                     // RULE_17 extension flag
                     exc_r <= 1'b1;
                     // RULE_08 interrupt at eight
                     irq_r <= 1'b1;
                     // RULE_18 matched prefix waits at eight
                     wait_r <= addr_match;
                  end
                  transmit_r <= shift_r[0];
               end
               if (clk_no == `CLK_ADDR_LAST) begin
                  if (is_master) begin
                     // RULE_11 master address
                     irq_r  <= 1'b1;
                     wait_r <= 1'b1;
                  end else if (selected_r && !ext_byte_r) begin
                     // RULE_06 match wait
                     irq_r  <= 1'b1;
                     wait_r <= 1'b1;
                  end else if (restart_r && !ext_byte_r) begin
                     // RULE_09 no wait
                     irq_r <= 1'b1;
                  end else if (lost_r) begin
                     // RULE_25 loss at nine
                     irq_r <= wait_timing_select_in;
                  end
                  // Extension codes were answered at clock eight
                  // RULE_10 otherwise silent
               end
            end else if (data_point
                         && (is_master || selected_r || (lost_r && wait_timing_select_in))) begin
               // RULE_05 data timing
               // RULE_23 post-loss interrupt
               irq_r  <= 1'b1;
               wait_r <= ~lost_r;
            end
            if (clk_no == `CLK_EIGHT && state_r == ST_DATA && !transmit_r && auto_ack_enable_in
                && (selected_r || is_master))
               ack_drv_r <= 1'b1;
            if (clk_no == `CLK_NINE && transmit_r && shift_r != sent_r)
               txerr_r <= 1'b1;
         end
         if (start_cond) begin
            std_r     <= 1'b1;
            spd_r     <= 1'b0;
            restart_r <= std_r & ~spd_r;
            // The start's own clock fall counts as clock zero
            clk_cnt_r <= `CNT_START;
            ext_byte_r <= 1'b0;
            wait_r    <= 1'b0;
            if (!master_mode_in) transmit_r <= 1'b0;
         end
         if (stop_cond) begin
            spd_r      <= 1'b1;
            std_r      <= 1'b0;
            selected_r <= 1'b0;
            restart_r  <= 1'b0;
            lost_r     <= 1'b0;
            wait_r     <= 1'b0;
            sda_drv_r  <= 1'b0;
            // RULE_14 stop interrupt
            // RULE_24 loss ends at stop
            irq_r <= stop_interrupt_enable_in;
         end
         if (bus_release_request_in) begin
            // RULE_19 leave slave role
            selected_r <= 1'b0;
            wait_r     <= 1'b0;
            ack_drv_r  <= 1'b0;
            sda_drv_r  <= 1'b0;
            transmit_r <= 1'b0;
         end
      end
   end

   // RULE_01 hold clock low
   assign scl_out    = 1'b0;
   assign scl_oe_out = wait_r & ~lost_r;
   assign sda_out    = 1'b0;
   // RULE_22 release lines
   assign sda_oe_out = (sda_drv_r | ack_drv_r) & ~lost_r;
   // RULE_27 single pulse
   assign serial_irq_out               = irq_r;
   assign waiting_out                  = wait_r;
   assign shift_register_out           = shift_r;
   assign extension_code_flag_out      = exc_r;
   assign address_coincidence_flag_out = coi_r;
   assign arbitration_lost_flag_out    = ald_r;
   assign start_detected_flag_out      = std_r;
   assign stop_detected_out            = spd_r;
   assign transmit_error_out           = txerr_r;
   assign general_call_out             = gcall_r;
   assign start_byte_out               = sbyte_r;
   assign ten_bit_out                  = tenb_r;
   assign slave_selected_out           = selected_r;
endmodule // twi_wait_ctrl

// file: bench/twi_wait_ctrl_checker.sv
// Checker for the wait and interrupt controller, bound to its ports.
// Assumes a single clk_in domain with synchronous active-low reset.
`timescale 1ns/1ps
module twi_wait_ctrl_checker (
   input  wire       clk_in,
   input  wire       nrst_in,
   input  wire       scl_in,
   input  wire       scl_oe_out,
   input  wire       wait_release_in,
   input  wire       data_write_in,
   input  wire [7:0] data_in,
   input  wire       stop_interrupt_enable_in,
   input  wire       serial_irq_out,
   input  wire       waiting_out,
   input  wire       stop_detected_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   chk_irq_pulse: assert property (serial_irq_out |=> !serial_irq_out)
      else $error("interrupt longer than one cycle");
   chk_wait_holds: assert property (waiting_out |-> scl_oe_out)
      else $error("wait without clock held low");
   chk_wrel_ends: assert property (waiting_out && wait_release_in |=> !waiting_out)
      else $error("release strobe did not end wait");
   chk_ff_ends: assert property (waiting_out && data_write_in && data_in == 8'hff |=> !waiting_out)
      else $error("all-ones write did not end wait");
   chk_wait_low: assert property ($rose(waiting_out) |-> !scl_in)
      else $error("wait began with clock high");
   chk_wait_irq: assert property ($rose(waiting_out) |-> serial_irq_out || $past(serial_irq_out))
      else $error("wait without interrupt");
   chk_stop_on: assert property ($rose(stop_detected_out) && stop_interrupt_enable_in |-> ##[0:1] serial_irq_out)
      else $error("enabled stop gave no interrupt");
   chk_stop_off: assert property ($rose(stop_detected_out) && !stop_interrupt_enable_in
      |-> !serial_irq_out ##1 !serial_irq_out)
      else $error("disabled stop gave interrupt");
   cover property (serial_irq_out);
   cover property (waiting_out && wait_release_in);
   cover property (waiting_out && data_write_in);
endmodule // twi_wait_ctrl_checker

bind twi_wait_ctrl twi_wait_ctrl_checker i_chk (.*);

// file: bench/twi_bus_master.sv
// Behavioural bus master on the far side of the controller.
// Assumes pulled-up open-drain lines resolved by the bench; 160 ns bit.
`timescale 1ns/1ps
module twi_bus_master (
   input  wire scl_in,
   input  wire sda_in,
   output reg  scl_oe_out,
   output reg  sda_oe_out
);
   initial begin
      scl_oe_out = 0;
      sda_oe_out = 0;
   end
   task rise;
      integer n;
      begin
         scl_oe_out = 0;
         n = 0;
         while (!scl_in && n < 2000) begin
            #10 n = n + 1;
         end
      end
   endtask
   task start_cond;
      begin
         sda_oe_out = 1;
         #80 scl_oe_out = 1;
         #40;
      end
   endtask
   task stop_cond;
      begin
         sda_oe_out = 1;
         #40 rise;
         #80 sda_oe_out = 0;
         #80;
      end
   endtask
   // one bit per clock, MSB first
   task send_byte(input [7:0] v, output ack);
      integer i;
      reg [8:0] b;
      begin
         b = {v, 1'b1};
         for (i = 8; i >= 0; i = i - 1) begin
            sda_oe_out = !b[i];
            #40 rise;
            #40 ack = sda_in;
            #40 scl_oe_out = 1;
            #40;
         end
         sda_oe_out = 0;
      end
   endtask
endmodule // twi_bus_master

// file: bench/twi_wait_ctrl_tb.sv
// Self-checking bench: bus master model drives frames into the slave.
// Assumes the checker is bound; waits are released by strobe or FFH write.
`timescale 1ns/1ps
module twi_wait_ctrl_tb;
   reg        clk_in, nrst_in, wtim, spie, rel_w, fclr, acke;
   reg  [7:0] wdat = 8'hff;
   reg  [7:0] rx_seen;
   reg        wrel = 0;
   reg        wr = 0;
   reg  [6:0] own;
   reg  [7:0] n_irq, base;
   integer    n_fail, samples_checked, seed, k;
   wire       scl_oe, sda_oe, m_scl, m_sda, irq, waiting, exc, coi, gc, sb, ten, ald, spd;
   wire       scl = !(scl_oe | m_scl);
   wire       sda = !(sda_oe | m_sda);
   wire [7:0] sreg;
   twi_wait_ctrl i_twi_wait_ctrl (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1), .scl_in(scl),
      .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe),
      .master_mode_in(1'b0), .wait_timing_select_in(wtim), .auto_ack_enable_in(acke),
      .stop_interrupt_enable_in(spie), .wait_release_in(wrel), .start_request_in(1'b0),
      .stop_request_in(1'b0), .bus_release_request_in(1'b0), .data_write_in(wr), .data_in(wdat),
      .own_slave_address_in(own), .flags_clear_in(fclr), .shift_register_out(sreg),
      .serial_irq_out(irq), .waiting_out(waiting), .extension_code_flag_out(exc),
      .address_coincidence_flag_out(coi), .arbitration_lost_flag_out(ald), .start_detected_flag_out(),
      .stop_detected_out(spd), .transmit_error_out(), .general_call_out(gc), .start_byte_out(sb),
      .ten_bit_out(ten), .slave_selected_out());
   twi_bus_master i_master (.scl_in(scl), .sda_in(sda), .scl_oe_out(m_scl), .sda_oe_out(m_sda));
   initial begin
      clk_in = 0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) n_irq <= nrst_in ? n_irq + irq : 8'h00;
   // Byte as software would read it when a wait interrupt arrives
   always @(posedge clk_in) if (irq && waiting) rx_seen <= sreg;
   always @(posedge clk_in) begin
      #1 wrel = waiting & !rel_w & !wrel;
      wr = waiting & rel_w & !wr;
   end
   task check(input [7:0] seen, input [7:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", samples_checked, n_fail);
         if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   function ext(input [7:0] a);
      ext = a[7:4] == 4'h0 || a[7:4] == 4'hf;
   endfunction
   task frame(input [7:0] a, input [7:0] d, input two);
      reg ack, dack;
      begin
         @(posedge clk_in) #1 fclr = 1;
         wtim = 1'($random(seed));
         // no master mode here, so no arbitration; stop interrupt random
         spie = 1'($random(seed));
         rel_w = 1'($random(seed));
         // acknowledge level fixed before any wait is released
         acke = 1'($random(seed));
         @(posedge clk_in) #1 fclr = 0;
         base = n_irq;
         i_master.start_cond;
         i_master.send_byte(a, ack);
         if (a[7:1] == own && !ext(a)) check({7'h0, ack}, 8'h00);
         if (a[7:1] != own && !ext(a)) check({7'h0, ack}, 8'h01);
         if (two) i_master.send_byte(d, dack);
         if (two) check({7'h0, dack}, {7'h0, !acke});
         i_master.stop_cond;
         repeat (8) @(posedge clk_in);
         check(n_irq - base, (a[7:1] == own || ext(a)) + two + spie);
         if (two) check(rx_seen, d);
         check({6'h0, ald, spd}, 8'h01);
         $display("frame %h done", a);
      end
   endtask
   task corner(input [7:0] a, input [6:0] o, input [4:0] f);
      begin
         own = o;
         frame(a, 8'h00, 1'b0);
         check({3'h0, exc, coi, gc, sb, ten}, {3'h0, f});
      end
   endtask
   initial begin
      // Sixteen frames of a few microseconds each need well under this
      #400000 n_fail = n_fail + 1;
      report_and_stop;
   end
   initial begin
      seed = 32'hfe64;
      n_fail = 0;
      samples_checked = 0;
      {nrst_in, wtim, spie, rel_w, fclr, acke} = 6'h00;
      own = 7'h2a;
      repeat (16) @(posedge clk_in);
      #1 nrst_in = 1;
      corner(8'h00, 7'h2a, 5'b10100);
      corner(8'h01, 7'h2a, 5'b10010);
      corner(8'hf0, 7'h78, 5'b11001);
      corner(8'hf2, 7'h2a, 5'b10001);
      for (k = 0; k < 12; k = k + 1) begin
         own = {3'b010, 4'($random(seed))};
         if (k[0]) frame({own, 1'b0}, 8'($random(seed)), 1'b1);
         else frame({3'b101, 5'($random(seed))}, 8'h00, 1'b0);
      end
      report_and_stop;
   end
endmodule // twi_wait_ctrl_tb
